// ### core/lcd_host_port.sv
// host register port of a character display controller
`timescale 1ns/1ns
// How it works
// R1: bus width bit picks 4 or 8-bit bus
// R2: select line picks instruction or data register
// R3: data goes to last selected ram
// R4: data read preloads next ram byte
// R5: data write copies byte into ram
// R6: instruction register is write only
// R7: select low write stores instruction code
// R8: select low read returns busy and address
// R9: select high write stores data byte
// R10: select high read returns data register
// R11: serial link carries writes only
// R12: serial link answers only with acknowledge
// R13: serial clock, data in, ack out separate
// R14: busy blocks new instructions until done
// R15: address counter steps after each ram access
// R16: header select bit routes following bytes
// R17: answers four write-only slave addresses
// R18: serial bytes share parallel write path
// R19: busy from accepted write until done

// --------------------------------------------------------------------
// byte fifo
// --------------------------------------------------------------------
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    always_comb begin
        in_ready = (cnt_reg != (AW+1)'(DEPTH));
        out_valid = (cnt_reg != '0);
        out_data = mem[rp_reg];
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        wp_next = push ? wp_reg + 1'b1 : wp_reg;
        rp_next = pop ? rp_reg + 1'b1 : rp_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end
endmodule

// --------------------------------------------------------------------
// host port top
// --------------------------------------------------------------------
module lcd_host_port
    import lcd_port_pkg::*;
(
    // clocks and reset
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic link_clk,
    // parallel host bus
    input wire logic strobe_pin,
    input wire logic register_select_line,
    input wire logic rw_pin,
    input wire logic [7:0] db_in,
    output logic [7:0] db_out,
    output logic db_oe,
    // serial link
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // status
    output logic internal_busy_flag
);
    function automatic logic [7:0] ram_index(input target_ram_e t, input logic [6:0] a);
        case (t)
            RAM_GLYPH: ram_index = {2'b10, a[5:0]};
            RAM_ICON: ram_index = {4'b1100, a[3:0]};
            default: ram_index = {1'b0, a};
        endcase
    endfunction

    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up);
        step_addr = up ? a + 7'h01 : a - 7'h01;
    endfunction

    // ----------------------------------------------------------------
    // parallel bus, sampled through two flops
    // ----------------------------------------------------------------
    pins_s pin_s1_reg, pin_s2_reg;
    logic strobe_prev_reg;
    logic nib_reg, nib_next;
    logic [3:0] hold_reg, hold_next;
    logic [7:0] db_out_reg, db_out_next;
    logic par_push, read_done;
    xfer_s par_word;

    // execution state
    exec_state_e ex_reg, ex_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [7:0] instruction_holding_register, ir_next_val;
    logic [7:0] data_holding_register, dh_next;
    logic [6:0] address_counter, adr_next;
    target_ram_e target_reg, target_next;
    logic bus_width_bit, width_next;
    logic step_up_reg, step_up_next;
    logic ext_reg, ext_next;
    logic [7:0] ram [256];
    logic ram_we;

    // fifo and crossing
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    xfer_s fifo_in, fifo_out;
    logic req_s1, req_s2, ack_tgl_reg, ack_tgl_next, ser_pending, ser_take;
    logic req_reg, req_next, sda_oe_reg, sda_oe_next, scl_oe_reg, scl_oe_next;
    xfer_s link_word_reg, link_word_next;

    always_ff @(posedge clk_sys) begin
        pin_s1_reg <= {strobe_pin, register_select_line, rw_pin, db_in};
        pin_s2_reg <= pin_s1_reg;
        strobe_prev_reg <= pin_s2_reg.strobe;
        req_s1 <= req_reg;
        req_s2 <= req_s1;
    end

    always_comb begin
        logic fall, done;
        logic [7:0] word, rd_word;
        fall = strobe_prev_reg & ~pin_s2_reg.strobe;
        // select low reads back busy and address, not the instruction
        rd_word = pin_s2_reg.sel ? data_holding_register // R2 R10 R6
                                 : {internal_busy_flag, address_counter}; // R8
        done = 1'b0;
        word = pin_s2_reg.db;
        nib_next = nib_reg;
        hold_next = hold_reg;
        if (fall) begin
            if (bus_width_bit) begin // R1
                done = 1'b1;
            end else if (!nib_reg) begin
                hold_next = pin_s2_reg.db[7:4];
                nib_next = 1'b1;
            end else begin
                word = {hold_reg, pin_s2_reg.db[7:4]};
                nib_next = 1'b0;
                done = 1'b1;
            end
        end
        if (bus_width_bit) begin
            db_out_next = rd_word;
        end else begin
            db_out_next = nib_reg ? {rd_word[3:0], 4'h0} : {rd_word[7:4], 4'h0};
        end
        par_push = done & ~pin_s2_reg.rw; // R7 R9
        par_word = {pin_s2_reg.sel, word};
        read_done = done & pin_s2_reg.rw & pin_s2_reg.sel;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            nib_reg <= 1'b0;
            hold_reg <= 4'h0;
            db_out_reg <= RST_BYTE;
        end else begin
            nib_reg <= nib_next;
            hold_reg <= hold_next;
            db_out_reg <= db_out_next;
        end
    end

    assign db_out = db_out_reg;
    assign db_oe = pin_s2_reg.strobe & pin_s2_reg.rw;

    // ----------------------------------------------------------------
    // one fifo for both paths; parallel wins a tie
    // ----------------------------------------------------------------
    always_comb begin
        ser_pending = req_s2 ^ ack_tgl_reg;
        fifo_in_valid = par_push | ser_pending; // R18
        fifo_in = par_push ? par_word : link_word_reg;
        ser_take = ser_pending & ~par_push & fifo_in_ready;
        ack_tgl_next = ack_tgl_reg ^ ser_take;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ack_tgl_reg <= 1'b0;
        end else begin
            ack_tgl_reg <= ack_tgl_next;
        end
    end

    byte_fifo #(
        .WIDTH($bits(xfer_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    // ----------------------------------------------------------------
    // execution of queued writes
    // ----------------------------------------------------------------
    // queued bytes show as busy so the fifo never overruns
    assign internal_busy_flag = (ex_reg != EX_IDLE) | fifo_out_valid; // R14 R19

    always_comb begin
        logic [7:0] b;
        b = fifo_out.byte_val;
        ex_next = ex_reg;
        cnt_next = cnt_reg;
        ir_next_val = instruction_holding_register;
        dh_next = data_holding_register;
        adr_next = address_counter;
        target_next = target_reg;
        width_next = bus_width_bit;
        step_up_next = step_up_reg;
        ext_next = ext_reg;
        ram_we = 1'b0;
        fifo_out_ready = 1'b0;
        case (ex_reg)
            EX_IDLE: begin
                if (read_done) begin
                    adr_next = step_addr(address_counter, step_up_reg); // R15
                    dh_next = ram[ram_index(target_reg, adr_next)]; // R4
                end else if (fifo_out_valid) begin
                    fifo_out_ready = 1'b1;
                    ex_next = EX_BUSY; // R19
                    cnt_next = EXEC_CYCLES - 8'h01;
                    if (fifo_out.sel) begin
                        dh_next = b;
                        ram_we = 1'b1; // R5 R3
                        adr_next = step_addr(address_counter, step_up_reg); // R15
                    end else begin
                        ir_next_val = b;
                        if (b[7]) begin
                            target_next = RAM_CHAR; // R3
                            adr_next = b[6:0];
                        end else if (ext_reg && b[7:4] == ICON_ADDR_CODE) begin
                            target_next = RAM_ICON;
                            adr_next = {3'h0, b[3:0]};
                        end else if (!ext_reg && b[7:6] == GLYPH_ADDR_CODE) begin
                            target_next = RAM_GLYPH;
                            adr_next = {1'b0, b[5:0]};
                        end else if (b[7:5] == FN_SET_CODE) begin
                            width_next = b[FN_WIDTH_BIT]; // R1
                            ext_next = b[FN_EXT_BIT];
                        end else if (b[7:2] == ENTRY_CODE) begin
                            step_up_next = b[ENTRY_DIR_BIT];
                        end
                        // address set preloads the first read
                        dh_next = ram[ram_index(target_next, adr_next)]; // R4
                    end
                end
            end
            EX_BUSY: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h00) begin
                    ex_next = EX_IDLE;
                end
            end
            default: ex_next = EX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ex_reg <= EX_IDLE;
            cnt_reg <= RST_BYTE;
            instruction_holding_register <= RST_BYTE;
            data_holding_register <= RST_BYTE;
            address_counter <= RST_ADDR;
            target_reg <= RAM_CHAR;
            bus_width_bit <= RST_BUS_WIDTH;
            step_up_reg <= RST_STEP_UP;
            ext_reg <= RST_EXT_SET;
        end else begin
            ex_reg <= ex_next;
            cnt_reg <= cnt_next;
            instruction_holding_register <= ir_next_val;
            data_holding_register <= dh_next;
            address_counter <= adr_next;
            target_reg <= target_next;
            bus_width_bit <= width_next;
            step_up_reg <= step_up_next;
            ext_reg <= ext_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ram_we) begin
            ram[ram_index(target_reg, address_counter)] <= fifo_out.byte_val;
        end
    end

    // ----------------------------------------------------------------
    // serial link slave, on link_clk
    // ----------------------------------------------------------------
    logic lrst_s1, lrst_s2, scl_s1, scl_s2, scl_prev, sda_s1, sda_s2, sda_prev;
    logic ack_s1, ack_s2;
    link_state_e lst_reg, lst_next, after_reg, after_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic last_header_marker, hdr_next, sel_reg, sel_next;

    always_ff @(posedge link_clk) begin
        lrst_s1 <= srst;
        lrst_s2 <= lrst_s1;
        scl_s1 <= scl_in; // R13
        scl_s2 <= scl_s1;
        scl_prev <= scl_s2;
        sda_s1 <= sda_in; // R13
        sda_s2 <= sda_s1;
        sda_prev <= sda_s2;
        ack_s1 <= ack_tgl_reg;
        ack_s2 <= ack_s1;
    end

    always_comb begin
        logic rise, fall;
        rise = scl_s2 & ~scl_prev;
        fall = ~scl_s2 & scl_prev;
        lst_next = lst_reg;
        after_next = after_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        hdr_next = last_header_marker;
        sel_next = sel_reg;
        req_next = req_reg;
        sda_oe_next = sda_oe_reg;
        scl_oe_next = scl_oe_reg;
        link_word_next = link_word_reg;
        if (scl_s2 && sda_prev && !sda_s2) begin
            lst_next = L_ADDR;
            bit_next = 4'h0;
            hdr_next = 1'b1;
            sda_oe_next = 1'b0;
        end else if (scl_s2 && !sda_prev && sda_s2) begin
            lst_next = L_IDLE;
            sda_oe_next = 1'b0;
        end else begin
            case (lst_reg)
                L_ADDR, L_CTRL, L_DATA: begin
                    if (rise) begin
                        shift_next = {shift_reg[6:0], sda_s2};
                        bit_next = bit_reg + 4'h1;
                    end else if (fall && bit_reg == BYTE_BITS) begin
                        bit_next = 4'h0;
                        if (lst_reg == L_ADDR) begin
                            // read requests are never acknowledged
                            if (shift_reg[7:3] == SLAVE_ADDR_HI && !shift_reg[0]) begin // R17 R11
                                sda_oe_next = 1'b1;
                                lst_next = L_ACK;
                                after_next = L_CTRL;
                            end else begin
                                lst_next = L_IDLE;
                            end
                        end else if (lst_reg == L_CTRL) begin
                            hdr_next = shift_reg[HDR_LAST_BIT];
                            sel_next = shift_reg[HDR_SEL_BIT]; // R16
                            sda_oe_next = 1'b1;
                            lst_next = L_ACK;
                            after_next = L_DATA;
                        end else begin
                            // stretch until the crossing is free
                            scl_oe_next = 1'b1;
                            lst_next = L_HAND;
                            after_next = last_header_marker ? L_CTRL : L_DATA; // R16
                        end
                    end
                end
                L_HAND: begin
                    if (req_reg == ack_s2) begin
                        link_word_next = {sel_reg, shift_reg}; // R18
                        req_next = ~req_reg;
                        sda_oe_next = 1'b1; // R12
                        lst_next = L_ACK;
                    end
                end
                L_ACK: begin
                    // ack settles before the stretch ends
                    scl_oe_next = 1'b0;
                    if (fall) begin
                        sda_oe_next = 1'b0;
                        lst_next = after_reg;
                    end
                end
                default: begin
                    sda_oe_next = 1'b0;
                    scl_oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst_s2) begin
            lst_reg <= L_IDLE;
            after_reg <= L_CTRL;
            bit_reg <= 4'h0;
            shift_reg <= RST_BYTE;
            last_header_marker <= 1'b1;
            sel_reg <= 1'b0;
            req_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            link_word_reg <= '0;
        end else begin
            lst_reg <= lst_next;
            after_reg <= after_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            last_header_marker <= hdr_next;
            sel_reg <= sel_next;
            req_reg <= req_next;
            sda_oe_reg <= sda_oe_next;
            scl_oe_reg <= scl_oe_next;
            link_word_reg <= link_word_next;
        end
    end

    // open-drain: only ever pull low
    assign sda_out = 1'b0; // R12
    assign sda_oe = sda_oe_reg;
    assign scl_out = 1'b0;
    assign scl_oe = scl_oe_reg;
endmodule

// ### inc/lcd_port_pkg.sv
// constants and types of the display controller host port
package lcd_port_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    // 500 ns of work in 100 ns cycles
    localparam logic [7:0] EXEC_CYCLES = 8'h05;

    // ----------------------------------------------------------------
    // reset values and field positions
    // ----------------------------------------------------------------
    localparam logic RST_BUS_WIDTH = 1'b1;
    localparam logic RST_STEP_UP = 1'b1;
    localparam logic RST_EXT_SET = 1'b0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [6:0] RST_ADDR = 7'h00;
    localparam int FN_WIDTH_BIT = 4;
    localparam int FN_EXT_BIT = 0;
    localparam int ENTRY_DIR_BIT = 1;
    localparam logic [2:0] FN_SET_CODE = 3'h1;
    localparam logic [5:0] ENTRY_CODE = 6'h01;
    localparam logic [1:0] GLYPH_ADDR_CODE = 2'h1;
    localparam logic [3:0] ICON_ADDR_CODE = 4'h4;
    localparam int HDR_LAST_BIT = 7;
    localparam int HDR_SEL_BIT = 6;

    // ----------------------------------------------------------------
    // serial link
    // ----------------------------------------------------------------
    localparam logic [4:0] SLAVE_ADDR_HI = 5'h0f;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int FIFO_DEPTH = 4;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {RAM_CHAR, RAM_GLYPH, RAM_ICON} target_ram_e;
    typedef enum logic [0:0] {EX_IDLE, EX_BUSY} exec_state_e;
    typedef enum logic [2:0] {L_IDLE, L_ADDR, L_CTRL, L_DATA, L_HAND, L_ACK} link_state_e;

    typedef struct packed {
        logic sel;
        logic [7:0] byte_val;
    } xfer_s;

    typedef struct packed {
        logic strobe;
        logic sel;
        logic rw;
        logic [7:0] db;
    } pins_s;

endpackage

// ### sim/host_port_assertions.sv
// concurrent checks on the host port, bound in
`timescale 1ns/1ns
module host_port_checker (
    // clocks and reset
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic link_clk,
    // parallel bus
    input wire logic strobe_pin,
    input wire logic register_select_line,
    input wire logic rw_pin,
    input wire logic [7:0] db_in,
    input wire logic [7:0] db_out,
    input wire logic db_oe,
    // serial link
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // status
    input wire logic internal_busy_flag
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    // pins pass two sync flops, so the bus lags two cycles
    property p_oe_read;
        @(posedge clk_sys) disable iff (srst) db_oe |-> $past(rw_pin, 2);
    endproperty
    property p_no_oe_write;
        @(posedge clk_sys) disable iff (srst)
        !rw_pin && !$past(rw_pin) && !$past(rw_pin, 2) |-> !db_oe;
    endproperty
    property p_read_stable;
        @(posedge clk_sys) disable iff (srst) (strobe_pin && rw_pin)[*8] |-> $stable(db_out);
    endproperty
    property p_busy_rise;
        @(posedge clk_sys) disable iff (srst)
        $fell(strobe_pin) && !rw_pin |-> ##[2:20] internal_busy_flag;
    endproperty
    property p_busy_min;
        @(posedge clk_sys) disable iff (srst)
        $rose(internal_busy_flag) |-> internal_busy_flag[*5];
    endproperty
    property p_busy_end;
        @(posedge clk_sys) disable iff (srst)
        $rose(internal_busy_flag) |-> ##[5:60] !internal_busy_flag;
    endproperty
    property p_ack_low;
        @(posedge link_clk) disable iff (srst) $rose(sda_oe) |-> !scl_in;
    endproperty
    property p_ack_hold;
        @(posedge link_clk) disable iff (srst) scl_in && $past(scl_in) |-> $stable(sda_oe);
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("bus driven outside a read");
    a_no_oe_write: assert property (p_no_oe_write) else $error("bus driven in a write");
    a_read_stable: assert property (p_read_stable) else $error("read value moved");
    a_busy_rise: assert property (p_busy_rise) else $error("busy missing after write");
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    a_busy_end: assert property (p_busy_end) else $error("busy never ends");
    a_ack_low: assert property (p_ack_low) else $error("ack began with clock high");
    a_ack_hold: assert property (p_ack_hold) else $error("ack moved with clock high");
    c_read: cover property (@(posedge clk_sys) (strobe_pin && rw_pin)[*8]);
    c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
    c_stretch: cover property (@(posedge link_clk) $rose(scl_oe));
endmodule
bind lcd_host_port host_port_checker u_chk (.clk_sys, .srst, .link_clk, .strobe_pin,
    .register_select_line, .rw_pin, .db_in, .db_out, .db_oe, .scl_in, .scl_out, .scl_oe,
    .sda_in, .sda_out, .sda_oe, .internal_busy_flag);

// ### sim/host_model.sv
// host model: parallel bus and write-only two-wire master
`timescale 1ns/1ns
module host_model (
    // clocks
    input wire logic clk_sys,
    input wire logic link_clk,
    // parallel bus
    output logic strobe_pin,
    output logic register_select_line,
    output logic rw_pin,
    output logic [7:0] db_in,
    input wire logic [7:0] db_out,
    input wire logic internal_busy_flag,
    // serial link, open drain with pull-ups
    output logic scl_in,
    output logic sda_in,
    input wire logic scl_oe,
    input wire logic sda_oe,
    // observed results
    output logic [7:0] res_val,
    output logic res_tick,
    output logic hang
);
    logic m_scl = 1'b1;
    logic m_sda = 1'b1;
    logic nib = 1'b0;
    assign scl_in = m_scl & ~scl_oe;
    assign sda_in = m_sda & ~sda_oe;
    initial {strobe_pin, register_select_line, rw_pin, res_tick, hang, db_in, res_val} = 21'h0;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic lk(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask
    task automatic idle();
        int n = 0;
        while (internal_busy_flag !== 1'b0 && n < 300) begin
            cyc(1);
            n++;
        end
        if (n == 300) hang = 1'b1;
    endtask
    task automatic strobe(input logic rs, rw, input logic [7:0] d, output logic [7:0] q);
        register_select_line = rs;
        rw_pin = rw;
        // released bus shows no stale byte
        db_in = rw ? ~db_in : d;
        cyc(1);
        strobe_pin = 1'b1;
        cyc(rw ? 9 : 4);
        q = db_out;
        strobe_pin = 1'b0;
        cyc(6);
    endtask
    task automatic wr(input logic rs, input logic [7:0] d);
        logic [7:0] q;
        idle();
        if (nib) strobe(rs, 1'b0, {d[7:4], 4'h0}, q);
        strobe(rs, 1'b0, nib ? {d[3:0], 4'h0} : d, q);
    endtask
    task automatic rd(input logic rs);
        logic [7:0] q, h;
        idle();
        strobe(rs, 1'b1, 8'h00, h);
        if (nib) strobe(rs, 1'b1, 8'h00, q);
        res_val = nib ? {h[7:4], q[7:4]} : h;
        res_tick = ~res_tick;
    endtask
    task automatic bit_io(input logic b, output logic s);
        int n = 0;
        lk(2);
        m_sda = b;
        lk(4);
        m_scl = 1'b1;
        // the device may stretch the clock
        while (scl_in !== 1'b1 && n < 1000) begin
            lk(1);
            n++;
        end
        if (n == 1000) hang = 1'b1;
        lk(3);
        s = sda_in;
        lk(3);
        m_scl = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(v[i], s);
        bit_io(1'b1, s);
        res_val = {7'h00, s};
        res_tick = ~res_tick;
    endtask
    task automatic start();
        m_sda = 1'b0;
        lk(6);
        m_scl = 1'b0;
    endtask
    task automatic stop();
        lk(2);
        m_sda = 1'b0;
        lk(6);
        m_scl = 1'b1;
        lk(6);
        m_sda = 1'b1;
        lk(6);
    endtask
endmodule

// ### sim/char_lcd_host_register_port_tb.sv
// self-checking bench of the display controller host port
`timescale 1ns/1ns
`define CHK(e, g) cmp(8'(e), 8'(g))
module char_lcd_host_register_port_tb;
    logic clk_sys = 1'b0, link_clk = 1'b0;
    logic srst = 1'b1;
    logic strobe_pin, register_select_line, rw_pin, db_oe, internal_busy_flag;
    logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, res_tick, hang;
    logic [7:0] db_in, db_out, res_val;
    logic [7:0] exp_q[$];
    logic [7:0] b[4], sq[5];
    logic [7:0] pre[3] = '{8'h30, 8'h30, 8'h31};
    logic [7:0] adr[3] = '{8'h85, 8'h45, 8'h45};
    logic [7:0] bad[2] = '{8'h70, 8'h79};
    int miscompares = 0;
    int check_count = 0;
    int seed = 32'h2827;
    always #50 clk_sys = ~clk_sys;
    always #3 link_clk = ~link_clk;
    lcd_host_port dut (.clk_sys, .srst, .link_clk, .strobe_pin, .register_select_line,
        .rw_pin, .db_in, .db_out, .db_oe, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out,
        .sda_oe, .internal_busy_flag);
    host_model p (.clk_sys, .link_clk, .strobe_pin, .register_select_line, .rw_pin, .db_in,
        .db_out, .internal_busy_flag, .scl_in, .sda_in, .scl_oe, .sda_oe, .res_val,
        .res_tick, .hang);
    // ----------------------------------------------------------------
    // checking
    // ----------------------------------------------------------------
    task automatic cmp(input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_rd(input logic rs, input logic [7:0] e);
        exp_q.push_back(e);
        p.rd(rs);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(res_tick) begin
        if (!srst) `CHK(exp_q.pop_front(), res_val);
    end
    always @(posedge hang) begin
        miscompares++;
        close_out();
    end
    initial begin
        for (int i = 0; i < 4; i++) b[i] = 8'($random(seed));
        repeat (6) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        `CHK(8'h00, {internal_busy_flag, db_oe, sda_oe, scl_oe, sda_out, scl_out});
        p.cyc(4);
        chk_rd(1'b0, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            p.wr(1'b0, pre[i]);
            p.wr(1'b0, adr[i]);
            p.wr(1'b1, b[i]);
        end
        for (int i = 0; i < 3; i++) begin
            p.wr(1'b0, pre[i]);
            p.wr(1'b0, adr[i]);
            chk_rd(1'b1, b[i]);
        end
        $display("test ram routing done");
        p.wr(1'b0, 8'h30);
        p.wr(1'b0, 8'h90);
        p.wr(1'b1, b[0]);
        p.wr(1'b1, b[1]);
        chk_rd(1'b0, 8'h12);
        p.wr(1'b0, 8'h04);
        p.wr(1'b0, 8'h91);
        chk_rd(1'b1, b[1]);
        chk_rd(1'b1, b[0]);
        chk_rd(1'b0, 8'h0f);
        p.wr(1'b0, 8'h06);
        $display("test address stepping done");
        p.wr(1'b0, 8'h20);
        p.nib = 1'b1;
        chk_rd(1'b0, 8'h0f);
        p.wr(1'b0, 8'h30);
        p.nib = 1'b0;
        chk_rd(1'b0, 8'h0f);
        $display("test bus width done");
        sq = '{8'h78, 8'h80, 8'ha0, 8'h40, b[3]};
        p.start();
        foreach (sq[i]) begin
            exp_q.push_back(8'h00);
            p.put_byte(sq[i]);
        end
        p.stop();
        // last byte still crossing domains
        p.cyc(10);
        chk_rd(1'b0, 8'h21);
        p.wr(1'b0, 8'ha0);
        chk_rd(1'b1, b[3]);
        foreach (bad[i]) begin
            p.start();
            exp_q.push_back(8'h01);
            p.put_byte(bad[i]);
            p.stop();
        end
        $display("test serial link done");
        close_out();
    end
endmodule
